// ===== verilog/spi_core_pkg.sv
package spi_core_pkg;

    // ****************************************
    // Clock and sizing
    // ****************************************
    localparam int CLOCK_HZ = 40_000_000;
    localparam int CLOCK_PERIOD_NS = 25;
    localparam int MAX_WIDTH = 16;
    localparam int MAX_SLAVES = 16;
    localparam int MIN_DIVISOR = 2;
    localparam int SYNC_STAGES = 2;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [MAX_SLAVES-1:0] SELECT_IDLE = 16'hFFFF;
    localparam logic RX_VALID_RESET = 1'h0;
    localparam logic TX_READY_RESET = 1'h1;

    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic sclk;
        logic ss_n;
        logic mosi;
        logic miso;
    } spi_pins_t;

    typedef struct packed {
        logic write;
        logic [MAX_WIDTH-1:0] data;
    } tx_req_t;

    typedef enum {
        ST_IDLE,
        ST_DELAY,
        ST_SHIFT,
        ST_END
    } master_state_t;

endpackage

// ===== verilog/spi_half_divider.sv
`timescale 1ns/1ps
`default_nettype none

module spi_half_divider
    import spi_core_pkg::*;
#(
    parameter int HALF = 1
) (
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire logic i_run,
    output logic o_tick
);

    localparam int CW = $clog2(HALF + 1);
    localparam logic [CW-1:0] LAST = CW'(HALF - 1);

    logic [CW-1:0] count;

    // ****************************************
    // Half-period tick, restarted by run
    // ****************************************
    assign o_tick = i_run && (count == LAST);

    always_ff @(posedge i_clock) begin
        if (!i_resetn || !i_run || o_tick) begin
            count <= '0;
        end else begin
            count <= count + CW'(1);
        end
    end

    property p_tick_spacing;
        @(posedge i_clock) disable iff (!i_resetn)
        (HALF > 1 && o_tick) |=> !o_tick;
    endproperty
    a_tick_spacing: assert property (p_tick_spacing) else $error("tick too close");

    property p_tick_needs_run;
        @(posedge i_clock) disable iff (!i_resetn)
        !i_run |-> !o_tick;
    endproperty
    a_tick_needs_run: assert property (p_tick_needs_run) else $error("tick while stopped");

endmodule

`default_nettype wire

// ===== verilog/spi_input_sync.sv
`timescale 1ns/1ps
`default_nettype none

module spi_input_sync
    import spi_core_pkg::*;
#(
    parameter int WIDTH = 3
) (
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire logic [WIDTH-1:0] i_d,
    output logic [WIDTH-1:0] o_q
);

    logic [WIDTH-1:0] stage;

    // ****************************************
    // Two flops; only the second is read
    // ****************************************
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            stage <= '1;
            o_q <= '1;
        end else begin
            stage <= i_d;
            o_q <= stage;
        end
    end

    property p_sync_delay;
        @(posedge i_clock) disable iff (!i_resetn)
        (i_resetn && $past(i_resetn) && $past(i_resetn, 2)) |-> (o_q == $past(i_d, 2));
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("sync latency wrong");

endmodule

`default_nettype wire

// ===== verilog/configurable_spi_core.sv
`timescale 1ns/1ps
`default_nettype none

module configurable_spi_core
    import spi_core_pkg::*;
#(
    parameter int IS_MASTER = 1,
    parameter int NUM_SLAVES = 1,
    parameter int TARGET_SCLK_HZ = 1_000_000,
    parameter int DELAY_ON = 0,
    parameter int DELAY_NS = 0,
    parameter int DATA_WIDTH = 8,
    parameter int LSB_FIRST = 0,
    parameter int CPOL = 0,
    parameter int CPHA = 0
) (
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire tx_req_t i_tx_req,
    input wire logic [MAX_SLAVES-1:0] i_slave_mask,
    input wire spi_pins_t i_pins,
    output logic [DATA_WIDTH-1:0] o_rx_data,
    output logic o_rx_valid,
    output logic o_tx_ready,
    output logic o_busy,
    output logic o_mosi,
    output logic o_sclk,
    output logic [NUM_SLAVES-1:0] o_ss_n,
    output logic o_miso
);

    // ****************************************
    // Derived timing
    // ****************************************
    localparam int W = DATA_WIDTH;
    localparam int RAW_DIV = 2 * ((CLOCK_HZ + 2 * TARGET_SCLK_HZ - 1) / (2 * TARGET_SCLK_HZ));
    localparam int DIVISOR = (RAW_DIV < MIN_DIVISOR) ? MIN_DIVISOR : RAW_DIV;
    localparam int HALF = DIVISOR / 2;
    localparam int HALF_NS = HALF * CLOCK_PERIOD_NS;
    localparam int DELAY_RAW = (DELAY_ON != 0) ? (DELAY_NS + HALF_NS - 1) / HALF_NS : 0;
    localparam logic [15:0] DELAY_UNITS = 16'(DELAY_RAW);
    localparam logic [5:0] LAST_EDGE = 6'(2 * W - 1);
    localparam logic [4:0] LAST_BIT = 5'(W - 1);
    localparam logic IDLE_LEVEL = 1'(CPOL);
    localparam int LEAD_CYCLES = (DELAY_RAW + 1) * HALF - 1;

    // ****************************************
    // Bit order helpers
    // ****************************************
    function automatic logic first_bit(input logic [W-1:0] s);
        first_bit = (LSB_FIRST != 0) ? s[0] : s[W-1];
    endfunction

    function automatic logic [W-1:0] shift_out(input logic [W-1:0] s);
        shift_out = (LSB_FIRST != 0) ? (s >> 1) : (s << 1);
    endfunction

    function automatic logic [W-1:0] shift_in(input logic [W-1:0] s, input logic b);
        if (LSB_FIRST != 0) begin
            shift_in = (s >> 1) | (W'(b) << (W - 1));
        end else begin
            shift_in = (s << 1) | W'(b);
        end
    endfunction

    // ****************************************
    // Declarations
    // ****************************************
    master_state_t state;
    logic tick;
    logic [15:0] delay_count;
    logic [5:0] edge_count;
    logic [19:0] lead_cycles;
    logic [2:0] synced;
    logic s_sclk;
    logic s_ss_n;
    logic s_mosi;
    logic sclk_prev;
    logic sel_prev;
    logic s_sel;
    logic [4:0] bit_count;
    logic [W-1:0] tx_hold;
    logic [W-1:0] tx_shift;
    logic [W-1:0] rx_shift;
    logic [W-1:0] next_rx;
    logic serial_out;
    logic m_start;
    logic s_start;
    logic start;
    logic edge_now;
    logic lead;
    logic drive_edge;
    logic sample_edge;
    logic word_done;
    logic load;
    logic in_bit;

    // ****************************************
    // Sub-blocks
    // ****************************************
    spi_half_divider #(
        .HALF(HALF)
    ) u_divider (
        .i_clock(i_clock),
        .i_resetn(i_resetn),
        .i_run(state != ST_IDLE),
        .o_tick(tick)
    );

    // Slave pins are asynchronous to us; sclk is oversampled here
    spi_input_sync #(
        .WIDTH(3)
    ) u_sync (
        .i_clock(i_clock),
        .i_resetn(i_resetn),
        .i_d({i_pins.sclk, i_pins.ss_n, i_pins.mosi}),
        .o_q(synced)
    );

    assign s_sclk = synced[2];
    assign s_ss_n = synced[1];
    assign s_mosi = synced[0];
    assign s_sel = !s_ss_n;

    // ****************************************
    // Edge classification, shared by both builds
    // ****************************************
    always_comb begin
        m_start = (state == ST_IDLE) && !o_tx_ready;
        s_start = s_sel && !sel_prev;
        if (IS_MASTER != 0) begin
            start = m_start;
            edge_now = (state == ST_SHIFT) && tick;
            lead = !edge_count[0];
            word_done = (state == ST_END) && tick;
            in_bit = i_pins.miso;
        end else begin
            start = s_start;
            edge_now = s_sel && (s_sclk != sclk_prev);
            lead = (s_sclk != IDLE_LEVEL);
            word_done = 1'b0;
            in_bit = s_mosi;
        end
        drive_edge = edge_now && (lead == (CPHA != 0));
        sample_edge = edge_now && (lead != (CPHA != 0));
        if (IS_MASTER == 0) begin
            word_done = sample_edge && (bit_count == LAST_BIT);
        end
        load = start || ((IS_MASTER == 0) && word_done);
        next_rx = sample_edge ? shift_in(rx_shift, in_bit) : rx_shift;
    end

    // ****************************************
    // Master sequencer
    // ****************************************
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (IS_MASTER != 0 && m_start) begin
                        state <= (DELAY_UNITS != 16'h0000) ? ST_DELAY : ST_SHIFT;
                    end
                end
                ST_DELAY: begin
                    if (tick && delay_count == DELAY_UNITS - 16'h0001) begin
                        state <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (tick && edge_count == LAST_EDGE) begin
                        state <= ST_END;
                    end
                end
                ST_END: begin
                    if (tick) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_resetn || state != ST_DELAY) begin
            delay_count <= 16'h0000;
        end else if (tick) begin
            delay_count <= delay_count + 16'h0001;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_resetn || state != ST_SHIFT) begin
            edge_count <= 6'h00;
        end else if (tick) begin
            edge_count <= edge_count + 6'h01;
        end
    end

    // Helper for the lead-time check only
    always_ff @(posedge i_clock) begin
        if (!i_resetn || start) begin
            lead_cycles <= 20'h00000;
        end else if (state != ST_IDLE && lead_cycles != 20'hFFFFF) begin
            lead_cycles <= lead_cycles + 20'h00001;
        end
    end

    // ****************************************
    // Serial clock and selects
    // ****************************************
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            o_sclk <= IDLE_LEVEL;
        end else if (IS_MASTER != 0 && state == ST_SHIFT && tick) begin
            o_sclk <= !o_sclk;
        end else if (state == ST_IDLE) begin
            o_sclk <= IDLE_LEVEL;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            o_ss_n <= SELECT_IDLE[NUM_SLAVES-1:0];
        end else if (IS_MASTER != 0 && m_start) begin
            o_ss_n <= ~i_slave_mask[NUM_SLAVES-1:0];
        end else if (state == ST_END && tick) begin
            o_ss_n <= SELECT_IDLE[NUM_SLAVES-1:0];
        end
    end

    // ****************************************
    // Slave input tracking
    // ****************************************
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            sclk_prev <= IDLE_LEVEL;
            sel_prev <= 1'b0;
        end else begin
            sclk_prev <= s_sclk;
            sel_prev <= s_sel;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_resetn || !s_sel) begin
            bit_count <= 5'h00;
        end else if (sample_edge) begin
            bit_count <= (bit_count == LAST_BIT) ? 5'h00 : bit_count + 5'h01;
        end
    end

    // ****************************************
    // Transmit path
    // ****************************************
    // A write in the load cycle survives: set wins over clear
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            tx_hold <= '0;
            o_tx_ready <= TX_READY_RESET;
        end else if (i_tx_req.write) begin
            tx_hold <= i_tx_req.data[W-1:0];
            o_tx_ready <= 1'b0;
        end else if (load) begin
            o_tx_ready <= 1'b1;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            tx_shift <= '0;
        end else if (load) begin
            tx_shift <= (start && CPHA == 0) ? shift_out(tx_hold) : tx_hold;
        end else if (drive_edge) begin
            tx_shift <= shift_out(tx_shift);
        end
    end

    // Phase 0 must present bit one before the first edge
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            serial_out <= 1'b0;
        end else if (start && CPHA == 0) begin
            serial_out <= first_bit(tx_hold);
        end else if (drive_edge) begin
            serial_out <= first_bit(tx_shift);
        end
    end

    // Slave miso is never tristated; gate externally if shared
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            o_mosi <= 1'b0;
            o_miso <= 1'b0;
        end else begin
            o_mosi <= (IS_MASTER != 0) ? next_mosi_bit() : 1'b0;
            o_miso <= (IS_MASTER != 0) ? 1'b0 : next_mosi_bit();
        end
    end

    function automatic logic next_mosi_bit();
        if (start && CPHA == 0) begin
            next_mosi_bit = first_bit(tx_hold);
        end else if (drive_edge) begin
            next_mosi_bit = first_bit(tx_shift);
        end else begin
            next_mosi_bit = serial_out;
        end
    endfunction

    // ****************************************
    // Receive path
    // ****************************************
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            rx_shift <= '0;
        end else begin
            rx_shift <= next_rx;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            o_rx_data <= '0;
            o_rx_valid <= RX_VALID_RESET;
        end else begin
            o_rx_valid <= word_done;
            if (word_done) begin
                o_rx_data <= next_rx;
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            o_busy <= 1'b0;
        end else begin
            o_busy <= (IS_MASTER != 0) ? (state != ST_IDLE) : s_sel;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    property p_sclk_idle;
        @(posedge i_clock) disable iff (!i_resetn)
        (state == ST_IDLE && !$past(tick)) |=> (o_sclk == IDLE_LEVEL);
    endproperty
    a_sclk_idle: assert property (p_sclk_idle) else $error("sclk not at idle level");

    property p_select_idle;
        @(posedge i_clock) disable iff (!i_resetn)
        (IS_MASTER != 0 && state == ST_END && tick) |=> (&o_ss_n);
    endproperty
    a_select_idle: assert property (p_select_idle) else $error("select left low");

    property p_delay_quiet;
        @(posedge i_clock) disable iff (!i_resetn)
        (state == ST_DELAY) |=> $stable(o_sclk) && !(&o_ss_n);
    endproperty
    a_delay_quiet: assert property (p_delay_quiet) else $error("sclk moved in delay");

    property p_lead_time;
        @(posedge i_clock) disable iff (!i_resetn)
        (IS_MASTER != 0 && state == ST_SHIFT && tick && edge_count == 6'h00)
            |-> (lead_cycles == 20'(LEAD_CYCLES));
    endproperty
    a_lead_time: assert property (p_lead_time) else $error("select lead wrong");

    property p_rx_move;
        @(posedge i_clock) disable iff (!i_resetn)
        word_done |=> o_rx_valid && (o_rx_data == $past(next_rx));
    endproperty
    a_rx_move: assert property (p_rx_move) else $error("rx word not moved");

    property p_tx_copy;
        @(posedge i_clock) disable iff (!i_resetn)
        (load && !i_tx_req.write) |=> o_tx_ready;
    endproperty
    a_tx_copy: assert property (p_tx_copy) else $error("tx hold not freed");

    property p_out_stable;
        @(posedge i_clock) disable iff (!i_resetn)
        (IS_MASTER != 0 && sample_edge) |=> $stable(o_mosi);
    endproperty
    a_out_stable: assert property (p_out_stable) else $error("mosi moved on sample edge");

    property p_edge_total;
        @(posedge i_clock) disable iff (!i_resetn)
        (state == ST_SHIFT && tick && edge_count == LAST_EDGE) |=> (o_sclk == IDLE_LEVEL);
    endproperty
    a_edge_total: assert property (p_edge_total) else $error("odd sclk edge count");

    property p_slave_first;
        @(posedge i_clock) disable iff (!i_resetn)
        (IS_MASTER == 0 && CPHA == 0 && s_start) |=> (o_miso == first_bit($past(tx_hold)));
    endproperty
    a_slave_first: assert property (p_slave_first) else $error("slave first bit late");

endmodule

`default_nettype wire

// ===== tb/spi_slave_model.sv
`timescale 1ns/1ps
`default_nettype none

module spi_slave_model #(
    parameter int CPOL = 0,
    parameter int CPHA = 0,
    parameter int W = 8
) (
    input wire logic i_sclk,
    input wire logic i_sel_n,
    input wire logic i_mosi,
    output logic o_miso,
    output logic [W-1:0] o_got,
    output logic o_got_valid
);
    // ****************************************
    // Word store and shifters
    // ****************************************
    logic [W-1:0] tx_q[$];
    logic [W-1:0] tx_sh;
    logic [W-1:0] rx_sh;
    int n;

    task automatic push(input logic [W-1:0] w);
        tx_q.push_back(w);
    endtask

    initial begin
        o_miso = 1'b0;
        o_got = '0;
        o_got_valid = 1'b0;
    end

    // ****************************************
    // Frame start: with CPHA 0, first bit before any edge
    // ****************************************
    always @(negedge i_sel_n) begin
        tx_sh = (tx_q.size() > 0) ? tx_q.pop_front() : '0;
        n = 0;
        rx_sh = '0;
        if (CPHA == 0) #1 o_miso = tx_sh[W-1];
    end

    // ****************************************
    // Edges, MSB first both ways
    // ****************************************
    always @(i_sclk) begin
        if (!i_sel_n && i_sclk != CPOL[0]) begin
            if (CPHA == 0) begin
                rx_sh = {rx_sh[W-2:0], i_mosi};
            end else begin
                #1 o_miso = tx_sh[W-1-n];
            end
        end else if (!i_sel_n) begin
            if (CPHA == 0) begin
                n++;
                if (n < W) #1 o_miso = tx_sh[W-1-n];
            end else begin
                rx_sh = {rx_sh[W-2:0], i_mosi};
                n++;
            end
        end
    end

    // ****************************************
    // Frame end: report, then stop holding data
    // ****************************************
    always @(posedge i_sel_n) begin
        o_got = rx_sh;
        o_got_valid = 1'b1;
        // Released line shows no stale bit
        o_miso = ~o_miso;
        #1 o_got_valid = 1'b0;
    end
endmodule

`default_nettype wire

// ===== tb/configurable_spi_core_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_errors++; \
    $display("mismatch at %0t: got %h want %h", $time, a, b); end end

module configurable_spi_core_tb_top;
    import spi_core_pkg::*;

    localparam int TARGET = 7_000_000;
    localparam int DLY = 100;
    localparam int W = 8;
    localparam int NS = 4;
    localparam int HALF = (CLOCK_HZ + 2 * TARGET - 1) / (2 * TARGET);
    localparam int UNITS = (DLY + HALF * CLOCK_PERIOD_NS - 1) / (HALF * CLOCK_PERIOD_NS);
    localparam int FIRST_GAP = (UNITS + 1) * HALF;
    localparam int LIMIT = 5000;
    localparam int POL = 1;
    localparam int PHA = 0;

    logic i_clock = 1'b0;
    logic i_resetn = 1'b0;
    tx_req_t i_tx_req = '0;
    logic [MAX_SLAVES-1:0] i_slave_mask = '0;
    spi_pins_t pins;
    logic miso_w;
    logic [W-1:0] o_rx_data;
    logic o_rx_valid, o_tx_ready, o_busy, o_mosi, o_sclk, o_miso;
    logic [NS-1:0] o_ss_n;
    wire logic sel_n = &o_ss_n;
    logic [W-1:0] got;
    logic got_valid;
    logic [W-1:0] exp_rx[$];
    logic [W-1:0] exp_mosi[$];
    logic [W-1:0] tmp, tmp2;
    int n_errors = 0;
    int n_checks = 0;
    int cycles = 0;
    int gap = 0;
    int edges = 0;
    logic prev_ss = 1'b1;
    logic prev_sclk = 1'b1;

    always #12.5 i_clock = ~i_clock;

    // Unused slave-build inputs held quiet
    assign pins = '{sclk: 1'b1, ss_n: 1'b1, mosi: 1'b0, miso: miso_w};

    configurable_spi_core #(.IS_MASTER(1), .NUM_SLAVES(NS), .TARGET_SCLK_HZ(TARGET),
        .DELAY_ON(1), .DELAY_NS(DLY), .DATA_WIDTH(W), .LSB_FIRST(0), .CPOL(POL),
        .CPHA(PHA)) u_dut (.i_clock(i_clock), .i_resetn(i_resetn), .i_tx_req(i_tx_req),
        .i_slave_mask(i_slave_mask), .i_pins(pins), .o_rx_data(o_rx_data),
        .o_rx_valid(o_rx_valid), .o_tx_ready(o_tx_ready), .o_busy(o_busy),
        .o_mosi(o_mosi), .o_sclk(o_sclk), .o_ss_n(o_ss_n), .o_miso(o_miso));

    spi_slave_model #(.CPOL(POL), .CPHA(PHA), .W(W)) u_slave (.i_sclk(o_sclk),
        .i_sel_n(sel_n), .i_mosi(o_mosi), .o_miso(miso_w), .o_got(got),
        .o_got_valid(got_valid));

    task automatic final_report();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ****************************************
    // Output watchers
    // ****************************************
    always @(posedge i_clock) begin
        cycles++;
        gap++;
        if (cycles > LIMIT) begin
            n_errors++;
            final_report();
        end
        if (i_resetn) begin
            if (o_rx_valid) begin
                tmp = exp_rx.size() ? exp_rx.pop_front() : ~o_rx_data;
                `CHK(o_rx_data, tmp)
            end
            if (sel_n) `CHK(o_sclk, 1'b1)
            if (sel_n !== prev_ss && !sel_n) `CHK(o_ss_n, ~i_slave_mask[NS-1:0])
            if (sel_n !== prev_ss) begin
                if (sel_n) `CHK(edges, 2 * W)
                gap = 0;
                edges = 0;
            end else if (o_sclk !== prev_sclk) begin
                if (edges == 0) `CHK(gap, FIRST_GAP)
                else `CHK(gap, HALF)
                gap = 0;
                edges++;
            end
        end
        prev_ss = sel_n;
        prev_sclk = o_sclk;
    end

    // Select leaving X at power-up is no frame
    always @(posedge got_valid) begin
        if (i_resetn) begin
            tmp2 = exp_mosi.size() ? exp_mosi.pop_front() : ~got;
            `CHK(got, tmp2)
        end
    end

    // ****************************************
    // Stimulus tasks
    // ****************************************
    task automatic xfer(input logic [15:0] m, input logic [W-1:0] d, input logic [W-1:0] s);
        u_slave.push(s);
        exp_rx.push_back(s);
        exp_mosi.push_back(d);
        @(posedge i_clock);
        i_tx_req <= '{write: 1'b1, data: {{(MAX_WIDTH-W){1'b0}}, d}};
        i_slave_mask <= m;
        @(posedge i_clock);
        i_tx_req.write <= 1'b0;
        @(negedge i_clock);
        `CHK(o_tx_ready, 1'b0)
    endtask

    task automatic wait_done();
        int i;
        for (i = 0; i < 1000; i++) begin
            @(negedge i_clock);
            if (exp_rx.size() == 0 && exp_mosi.size() == 0 && o_busy === 1'b0) break;
        end
        `CHK(i < 1000, 1'b1)
        `CHK(o_tx_ready, 1'b1)
        `CHK(o_miso, 1'b0)
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        int k;
        void'($urandom(32'hCA62));
        repeat (10) @(posedge i_clock);
        @(negedge i_clock);
        `CHK(o_ss_n, {NS{1'b1}})
        `CHK(o_sclk, 1'b1)
        `CHK(o_tx_ready, 1'b1)
        `CHK(o_rx_valid, 1'b0)
        @(posedge i_clock);
        i_resetn <= 1'b1;
        // Each select alone, then two at once
        for (k = 0; k < 5; k++) begin
            xfer((k < NS) ? (16'h1 << k) : 16'h000A, W'($urandom), W'($urandom));
            wait_done();
        end
        // Boundary words
        xfer(16'h0001, 8'h00, 8'hFF);
        wait_done();
        xfer(16'h0008, 8'h81, 8'h01);
        wait_done();
        // Second word queued during the first word's select delay, before it shifts
        xfer(16'h0004, W'($urandom), W'($urandom));
        for (k = 0; k < 50 && o_tx_ready !== 1'b1; k++) @(negedge i_clock);
        // Busy trails the sequencer by one cycle
        @(negedge i_clock);
        `CHK(o_busy, 1'b1)
        xfer(16'h0004, W'($urandom), W'($urandom));
        wait_done();
        `CHK(o_sclk, 1'b1)
        final_report();
    end
endmodule

`default_nettype wire
